// ### rtl/vector_step_pkg.sv
// What this block does
// - Each step adds the ones-complement minor delta and a carry-in of one.
// - No carry out strobes both major and minor axis, a diagonal step.
// - A carry out strobes the major axis only and sets the carry flop.
// - A diagonal step shows direction X-and-Y, writes once unless on an even line after direction 6, counts down.
// - A major-only step shows direction X, writes once, counts down.
// - No write for direction 2 on odd lines or direction 6 on even lines.
// - No write for direction 5 or 7 on an even line after direction 6.
// - No write for direction 1 or 3 on an odd line after direction 2.
package vector_step_pkg;
  localparam int          DataWidth   = 8;
  localparam int          CountWidth  = 8;
  localparam logic [2:0]  DirDecX     = 3'h4;
  localparam logic [2:0]  DirDecXY    = 3'h5;
  localparam logic [2:0]  DirReset    = 3'h0;
  localparam logic        CarryIn     = 1'h1;

  typedef enum logic [1:0] {
    IDLE = 2'b00,
    STEP = 2'b01,
    ADDU = 2'b10,
    DONE = 2'b11
  } step_state_e;

  typedef struct packed {
    logic       valid;
    logic [2:0] dir;
    logic       write;
  } pixel_req_s;
endpackage : vector_step_pkg

// ### rtl/pixel_write_gate.sv
`timescale 1ns/100ps
`default_nettype none
module pixel_write_gate
  import vector_step_pkg::*;
(
  // Step information
  input  wire logic [2:0] dir,
  input  wire logic [2:0] prevDir,
  input  wire logic       lineOdd,
  // Decision
  output var  logic       allow
);
  always_comb begin
    allow = 1'b1;
    if ((dir == 3'h2 && lineOdd) || (dir == 3'h6 && !lineOdd)) begin
      allow = 1'b0;
    end
    if ((dir == 3'h5 || dir == 3'h7) && !lineOdd && prevDir == 3'h6) begin
      allow = 1'b0;
    end
    if ((dir == 3'h1 || dir == 3'h3) && lineOdd && prevDir == 3'h2) begin
      allow = 1'b0;
    end
  end
endmodule : pixel_write_gate
`default_nettype wire

// ### rtl/vector_step_generator.sv
`timescale 1ns/100ps
`default_nettype none
module vector_step_generator
  import vector_step_pkg::*;
#(
  parameter int DW = DataWidth,
  parameter int CW = CountWidth
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          clkEn,
  // Vector setup
  input  wire logic          start,
  input  wire logic [DW-1:0] errorInit,
  input  wire logic [DW-1:0] minorDeltaComplement,
  input  wire logic [DW-1:0] majorDeltaValue,
  input  wire logic [CW-1:0] stepCount,
  input  wire logic [2:0]    prevDirInit,
  input  wire logic          lineOdd,
  // Step outputs
  output var  pixel_req_s    pixelReq,
  output var  logic          majorStrobe,
  output var  logic          minorStrobe,
  output var  logic          carryFlag,
  output var  logic [DW-1:0] errorTerm,
  output var  logic [CW-1:0] downCount,
  output var  logic          busy,
  output var  logic          vectorDone
);
  // Adders and counter need these widths
  if (DW < 2 || CW < 1) begin : g_widthCheck
    $error("vector_step_generator: width too small");
  end

  step_state_e   state_q;
  logic [DW-1:0] err_q;
  logic [DW-1:0] minorComp_q;
  logic [DW-1:0] majorDelta_q;
  logic [CW-1:0] cnt_q;
  logic          carry_q;
  logic [2:0]    prevDir_q;
  logic [DW:0]   sumErr;
  logic [DW:0]   sumAddBack;
  logic [2:0]    dirNow;
  logic          allow;

  assign sumErr     = {1'b0, err_q} + {1'b0, minorComp_q}
                      + {{DW{1'b0}}, CarryIn};
  assign sumAddBack = {1'b0, err_q} + {1'b0, majorDelta_q};
  assign dirNow     = sumErr[DW] ? DirDecX : DirDecXY;

  pixel_write_gate u_gate (
    .dir     (dirNow),
    .prevDir (prevDir_q),
    .lineOdd (lineOdd),
    .allow   (allow)
  );

  // Sequencing
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= IDLE;
    end else if (clkEn) begin
      case (state_q)
        IDLE: if (start) begin
          state_q <= (stepCount == '0) ? DONE : STEP;
        end
        STEP: state_q <= ADDU;
        ADDU: state_q <= (cnt_q == '0) ? DONE : STEP;
        DONE: state_q <= IDLE;
        default: state_q <= IDLE;
      endcase
    end
  end

  // Error term and deltas
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      err_q        <= '0;
      minorComp_q  <= '0;
      majorDelta_q <= '0;
      carry_q      <= 1'b0;
    end else if (clkEn) begin
      if (state_q == IDLE && start) begin
        err_q        <= errorInit;
        minorComp_q  <= minorDeltaComplement;
        majorDelta_q <= majorDeltaValue;
        carry_q      <= 1'b0;
      end else if (state_q == STEP) begin
        err_q   <= sumErr[DW-1:0];
        carry_q <= sumErr[DW];
      end else if (state_q == ADDU && !carry_q) begin
        err_q <= sumAddBack[DW-1:0];
      end
    end
  end

  // Count, direction and pixel request
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_q       <= '0;
      prevDir_q   <= DirReset;
      pixelReq    <= '0;
      majorStrobe <= 1'b0;
      minorStrobe <= 1'b0;
    end else if (clkEn) begin
      pixelReq    <= '0;
      majorStrobe <= 1'b0;
      minorStrobe <= 1'b0;
      if (state_q == IDLE && start) begin
        cnt_q     <= stepCount;
        prevDir_q <= prevDirInit;
      end else if (state_q == STEP) begin
        majorStrobe    <= 1'b1;
        minorStrobe    <= !sumErr[DW];
        pixelReq.valid <= 1'b1;
        pixelReq.dir   <= dirNow;
        pixelReq.write <= allow;
        prevDir_q      <= dirNow;
        cnt_q          <= cnt_q - 1'b1;
      end
    end
  end

  // Status outputs
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      carryFlag  <= 1'b0;
      errorTerm  <= '0;
      downCount  <= '0;
      busy       <= 1'b0;
      vectorDone <= 1'b0;
    end else if (clkEn) begin
      carryFlag  <= carry_q;
      errorTerm  <= err_q;
      downCount  <= cnt_q;
      busy       <= (state_q == STEP) || (state_q == ADDU)
                    || (state_q == IDLE && start);
      vectorDone <= (state_q == DONE);
    end
  end

  // Checks
  sequence s_stepIssued;
    state_q == STEP;
  endsequence

  a_diag_no_carry: assert property (@(posedge clk) disable iff (!reset_n)
    (s_stepIssued and clkEn and !sumErr[DW]) |=> (minorStrobe && majorStrobe))
    else $error("diagonal step lacks strobes");
  a_major_only: assert property (@(posedge clk) disable iff (!reset_n)
    (s_stepIssued and clkEn and sumErr[DW]) |=> (!minorStrobe && carry_q))
    else $error("carry step wrong");
  a_diag_dir: assert property (@(posedge clk) disable iff (!reset_n)
    (minorStrobe) |-> (pixelReq.valid && pixelReq.dir == DirDecXY))
    else $error("diagonal direction wrong");
  a_major_dir: assert property (@(posedge clk) disable iff (!reset_n)
    (majorStrobe && !minorStrobe) |-> (pixelReq.dir == DirDecX))
    else $error("major direction wrong");
  a_count_step: assert property (@(posedge clk) disable iff (!reset_n)
    (s_stepIssued and clkEn) |=> (cnt_q == $past(cnt_q) - 1'b1))
    else $error("count not decremented");
  a_err_add: assert property (@(posedge clk) disable iff (!reset_n)
    (s_stepIssued and clkEn) |=>
      (err_q == $past(err_q) + $past(minorComp_q) + 1'b1))
    else $error("error term wrong");
  a_gate_even6: assert property (@(posedge clk) disable iff (!reset_n)
    (dirNow == 3'h6 && !lineOdd) |-> !allow)
    else $error("write not suppressed");
  a_gate_prev6: assert property (@(posedge clk) disable iff (!reset_n)
    (dirNow == 3'h5 && !lineOdd && prevDir_q == 3'h6) |-> !allow)
    else $error("write not suppressed after 6");
  a_gate_prev2: assert property (@(posedge clk) disable iff (!reset_n)
    (dirNow == 3'h1 && lineOdd && prevDir_q == 3'h2) |-> !allow)
    else $error("write not suppressed after 2");
  a_done_stop: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == ADDU && clkEn && cnt_q == '0) |=> ##1 vectorDone)
    else $error("completion missing");

  // Step bookkeeping and completion
  sequence s_lastStep;
    state_q == ADDU && cnt_q == '0;
  endsequence

  a_prev6_out: assert property (@(posedge clk) disable iff (!reset_n)
    (s_stepIssued and clkEn and dirNow == DirDecXY and !lineOdd
      and prevDir_q == 3'h6) |=> !pixelReq.write)
    else $error("write after direction 6 not suppressed");
  a_add_back: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == ADDU && clkEn && !carry_q) |=>
      (err_q == $past(err_q) + $past(majorDelta_q)))
    else $error("add-back after diagonal step wrong");
  a_carry_keep: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == ADDU && clkEn && carry_q) |=> (err_q == $past(err_q)))
    else $error("error term changed after carry step");
  a_minor_pair: assert property (@(posedge clk) disable iff (!reset_n)
    minorStrobe |-> majorStrobe)
    else $error("minor strobe without major strobe");
  a_write_valid: assert property (@(posedge clk) disable iff (!reset_n)
    pixelReq.write |-> pixelReq.valid)
    else $error("write without pixel request");
  a_last_stop: assert property (@(posedge clk) disable iff (!reset_n)
    (s_lastStep and clkEn) |=> (state_q == DONE))
    else $error("stepping did not stop");
  a_no_stray: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q != STEP && clkEn) |=> (!pixelReq.valid && !majorStrobe))
    else $error("step pulse outside a step");
  a_done_idle: assert property (@(posedge clk) disable iff (!reset_n)
    vectorDone |-> (!busy && state_q == IDLE))
    else $error("completion while still stepping");
  a_step_nonzero: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == STEP) |-> (cnt_q != '0))
    else $error("step issued with empty count");
  a_no_restart: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == STEP && clkEn) |=> (state_q == ADDU))
    else $error("step sequence broken");
  a_frozen: assert property (@(posedge clk) disable iff (!reset_n)
    (!clkEn) |=> ($stable(state_q) && $stable(cnt_q)))
    else $error("state moved while clock enable low");
endmodule : vector_step_generator
`default_nettype wire

// ### dv/pixel_sink.sv
`timescale 1ns/100ps
`default_nettype none
module pixel_sink
  import vector_step_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Pixel requests
  input  wire pixel_req_s pixelReq,
  // Tally of performed writes
  output var  int         writes
);
  always_ff @(posedge clk) begin
    if (!reset_n) writes <= 0;
    else if (pixelReq.valid && pixelReq.write) writes <= writes + 1;
  end
endmodule : pixel_sink
`default_nettype wire

// ### dv/vector_step_generator_test.sv
`timescale 1ns/100ps
`default_nettype none
module vector_step_generator_test;
  import vector_step_pkg::*;
  logic       clk, reset_n, clkEn, start, lineOdd, majorStrobe, minorStrobe;
  logic       carryFlag, busy, vectorDone;
  logic [7:0] errorInit, mdc, majorDelta, stepCount, errorTerm, downCount;
  logic [2:0] prevDirInit;
  pixel_req_s pixelReq;
  int         writes, num_errors, n_compared, seed;
  vector_step_generator u_vector_step_generator (.clk(clk),
    .reset_n(reset_n), .clkEn(clkEn), .start(start), .errorInit(errorInit),
    .minorDeltaComplement(mdc), .majorDeltaValue(majorDelta),
    .stepCount(stepCount),
    .prevDirInit(prevDirInit), .lineOdd(lineOdd), .pixelReq(pixelReq),
    .majorStrobe(majorStrobe), .minorStrobe(minorStrobe),
    .carryFlag(carryFlag), .errorTerm(errorTerm), .downCount(downCount),
    .busy(busy), .vectorDone(vectorDone));
  pixel_sink u_pixel_sink (.clk(clk), .reset_n(reset_n),
    .pixelReq(pixelReq), .writes(writes));
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (exp !== got) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic run(logic [7:0] e, m, d, n, logic [2:0] p, logic o);
    logic [8:0] s;
    logic [7:0] er;
    logic [2:0] pv, dir;
    logic       w, c;
    int         w0, nw, k;
    repeat (2) @(posedge clk);
    errorInit <= e; mdc <= m; majorDelta <= d; stepCount <= n;
    prevDirInit <= p; lineOdd <= o; start <= 1'b1; clkEn <= 1'b0;
    @(posedge clk);
    @(negedge clk) check("frozen", 0, busy);
    @(posedge clk) clkEn <= 1'b1;
    @(posedge clk) start <= 1'b0;
    er = e; pv = p; nw = 0; w0 = writes; c = 1'b0;
    for (int i = 0; i < n; i++) begin
      s = er + m + 9'h001;
      dir = s[8] ? DirDecX : DirDecXY;
      w = !((dir == 2 && o) || (dir == 6 && !o) || ((dir == 5 || dir == 7)
        && !o && pv == 6) || ((dir == 1 || dir == 3) && o && pv == 2));
      nw += w;
      k = 0;
      while (pixelReq.valid !== 1'b1 && k < 20) begin
        @(negedge clk);
        k++;
      end
      check("dir", dir, pixelReq.dir);
      check("write", w, pixelReq.write);
      check("minor", !s[8], minorStrobe);
      check("major", 1, majorStrobe);
      check("busy", 1, busy);
      check("error", er, errorTerm);
      check("carry", c, carryFlag);
      check("count", n - 8'(i), downCount);
      er = s[7:0] + (s[8] ? 8'h00 : d);
      c = s[8];
      pv = dir;
      if (i == 0 && n > 1) begin
        @(posedge clk);
        start <= 1'b1;
        stepCount <= 8'h00;
        @(posedge clk) start <= 1'b0;
      end
      @(negedge clk);
    end
    k = 0;
    while (vectorDone !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    check("done", 1, vectorDone);
    check("writes", 8'(nw), 8'(writes - w0));
    check("final error", er, errorTerm);
    check("final carry", c, carryFlag);
    check("final count", 0, downCount);
    check("idle", 0, busy);
  endtask : run
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    num_errors++;
    close_out();
  end
  initial begin
    seed = 32'hC398; reset_n = 0; clkEn = 1; start = 0; lineOdd = 0;
    errorInit = 0; mdc = 0; majorDelta = 0; stepCount = 0; prevDirInit = 0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    run(8'h02, 8'hFC, 8'h05, 8'h05, 3'h0, 1'b0);
    run(8'h02, 8'hFC, 8'h05, 8'h03, 3'h6, 1'b0);
    run(8'h02, 8'hFC, 8'h05, 8'h03, 3'h2, 1'b1);
    run(8'h02, 8'hFC, 8'h05, 8'h00, 3'h6, 1'b0);
    for (int i = 0; i < 8; i++) begin
      run(8'($random(seed)), 8'($random(seed)), 8'($random(seed)),
        8'($random(seed) & 15), 3'($random(seed)), 1'($random(seed)));
    end
    close_out();
  end
endmodule : vector_step_generator_test
`default_nettype wire
